//--- logic/cpm_pkg.sv
// shared constants and types for the configuration pin mode select block
// assumes one 100 MHz core clock and an external two-wire serial master
package cpm_pkg;

	// register indices seen over the serial port
	localparam logic [7:0] CPM_REG_CTRL_IDX  = 8'h08;
	localparam logic [7:0] CPM_REG_STAT_IDX  = 8'h09;
	localparam logic [7:0] CPM_REG_TRIM_IDX  = 8'h0a;

	// control register field positions
	localparam int         CPM_CTRL_PD_BIT   = 0;
	localparam int         CPM_CTRL_EDGE_BIT = 1;
	localparam int         CPM_CTRL_BUS_WIDTH_SELECT_BIT = 2;
	localparam int         CPM_CTRL_CLOCK_MODE_SELECT_BIT = 3;
	localparam int         CPM_CTRL_DESKEW_ENABLE_PIN_BIT = 4;

	// status register field positions
	localparam int         CPM_STAT_HPD_BIT  = 0;

	// reset values: powered down, 24-bit, rising edge, no de-skew
	localparam logic [7:0] CPM_CTRL_RST      = 8'h06;
	localparam logic [2:0] CPM_TRIM_RST      = 3'h4;

	// upper four slave address bits, value is arbitrary
	localparam logic [3:0] CPM_SLAVE_ADDR_HI = 4'h7;

	// serial bit counter landmarks
	localparam logic [3:0] CPM_BIT_LAST      = 4'h7;
	localparam logic [3:0] CPM_BIT_ACK       = 4'h8;

	// serial slave byte phases
	typedef enum logic [2:0] {
		LS_ADDR  = 3'b000,
		LS_REG   = 3'b001,
		LS_WDATA = 3'b010,
		LS_READ  = 3'b011,
		LS_IDLE  = 3'b100
	} cpm_lstate_t;

endpackage

//--- logic/cpm_cfg_if.sv
// carries serial-written settings from the link domain to the core domain
// assumes ctrl and trim stay stable for many core cycles after a toggle
interface cpm_cfg_if;
	logic       wr_tgl;
	logic [7:0] ctrl;
	logic [2:0] trim;

	modport link (output wr_tgl, output ctrl, output trim);
	modport core (input wr_tgl, input ctrl, input trim);
endinterface

//--- logic/cpm_sync2.sv
// two flip-flop level synchroniser, any width
// assumes each bit is a slow level; words must be otherwise held stable
module cpm_sync2 #(
	parameter int W = 1
) (
	input  wire logic         clk_in,
	input  wire logic         arst_n_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	logic [W-1:0] meta_q;

	// first stage feeds only the second stage
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			meta_q <= '0;
			q_out  <= '0;
		end
		else
		begin
			meta_q <= d_in;
			q_out  <= meta_q;
		end
	end
endmodule // cpm_sync2

//--- logic/cpm_cfg_regs.sv
// core-domain copy of the serial control and trim registers
// assumes the link side toggles wr_tgl after its words have settled
module cpm_cfg_regs
	import cpm_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       arst_n_in,
	input  wire logic       serial_en_in,
	cpm_cfg_if.core         cfg,
	output logic      [7:0] ctrl_out,
	output logic      [2:0] trim_out
);
	logic tgl_s;
	logic tgl_d1_q;

	// event crossing: only the toggle is synchronised
	cpm_sync2 #(.W(1)) u_tgl_sync (
		.clk_in    (clk_in),
		.arst_n_in (arst_n_in),
		.d_in      (cfg.wr_tgl),
		.q_out     (tgl_s)
	);

	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			tgl_d1_q <= 1'b0;
		else
			tgl_d1_q <= tgl_s;
	end

	// copy forgets everything while the port is off
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			ctrl_out <= CPM_CTRL_RST;
			trim_out <= CPM_TRIM_RST;
		end
		else if (!serial_en_in)
		begin
			ctrl_out <= CPM_CTRL_RST;
			trim_out <= CPM_TRIM_RST;
		end
		else if (tgl_s != tgl_d1_q)
		begin
			ctrl_out <= cfg.ctrl; // held stable by the link side
			trim_out <= cfg.trim;
		end
	end
endmodule // cpm_cfg_regs

//--- logic/cpm_config_pin_mode_select.sv
// multifunction configuration pin decoder with a serial slave port
// assumes board straps are static and the serial master drives scl;
// scl may stop between frames, so framing is watched from the core clock
//
// Overview of operation
// - port select high enables serial slave; registers start at defaults.
// - port select low disables serial; straps give configuration and state.
// - port select low then high resets slave state and all registers.
// - strap mode, bus width pin high is 24-bit single-edge, low 12-bit.
// - serial mode, bus width pin is clock, clock mode pin is data.
// - strap mode, clock mode, bus width and swing pick pixel clock style.
// - strap mode, latch pin high latches on rising edge, low falling.
// - latch edge choice holds for single-ended and differential clocks.
// - serial mode, latch pin becomes the hot-plug sense input.
// - de-skew shifts clock-to-data timing in whole trim steps.
// - strap mode, de-skew pin high enables de-skew, trim from pins.
// - strap mode, de-skew pin low disables de-skew, default trim used.
// - serial mode ignores de-skew pin; enable and trim come from registers.
// - three shared pins are address bits, trim, or blanking controls.
// - port select doubles as asynchronous active-low serial reset.
// - strap mode power pin high runs, low powers down; serial default off.
module cpm_config_pin_mode_select
	import cpm_pkg::*;
#(
	parameter int TRIM_STEP_PS = 100
) (
	input  wire logic        clk_in,
	input  wire logic        arst_n_in,
	input  wire logic        serial_port_select_in,
	input  wire logic        bus_width_select_in,
	input  wire logic        clock_mode_select_in,
	input  wire logic        latch_polarity_select_in,
	input  wire logic        input_swing_low_in,
	input  wire logic        powerdown_n_in,
	input  wire logic        deskew_enable_pin_in,
	input  wire logic [2:0]  multifunction_in,
	output logic             serial_enabled_out,
	output logic             input_24bit_out,
	output logic             clock_differential_out,
	output logic             latch_rising_out,
	output logic             deskew_enable_out,
	output logic [2:0]       deskew_trim_out,
	output logic [11:0]      deskew_delay_ps_out,
	output logic [2:0]       blank_control_out,
	output logic             powered_on_out,
	output logic             hot_plug_sense_out,
	output logic             sda_out,
	output logic             sda_oe_n_out
);

	// core-domain view of every pin
	logic        serial_port_select_s;
	logic        bus_width_select_s;
	logic        clock_mode_select_s;
	logic        edge_s;
	logic        swing_s;
	logic        pd_s;
	logic        deskew_enable_pin_s;
	logic [2:0]  mf_s;

	// framing watch on the serial lines, core domain
	logic        scl_d1_q;
	logic        sda_d1_q;
	logic        frame_hold_q;
	logic        start_seen;
	logic        stop_seen;
	logic        frame_rst_n;

	// link-domain state, clocked by the serial clock pin
	cpm_lstate_t lstate_q;
	logic [3:0]  bit_cnt_q;
	logic [6:0]  shift_q;
	logic [7:0]  byte_now;
	logic [7:0]  ptr_q;
	logic [7:0]  tx_q;
	logic        ack_q;
	logic        rd_pend_q;
	logic [7:0]  ctrl_q;
	logic [2:0]  trim_q;
	logic        wr_tgl_q;
	logic [3:0]  link_pins_s;
	logic [7:0]  rd_data;

	// registered settings in the core domain
	logic [7:0]  reg_ctrl;
	logic [2:0]  reg_trim;
	logic [2:0]  trim_d;

	cpm_cfg_if cfg ();

	// straps pass two flops before any decode reads them
	cpm_sync2 #(.W(10)) u_pin_sync (
		.clk_in    (clk_in),
		.arst_n_in (arst_n_in),
		.d_in      ({serial_port_select_in, bus_width_select_in,
		              clock_mode_select_in, latch_polarity_select_in,
		              input_swing_low_in, powerdown_n_in,
		              deskew_enable_pin_in, multifunction_in}),
		.q_out     ({serial_port_select_s, bus_width_select_s, clock_mode_select_s, edge_s, swing_s, pd_s,
		              deskew_enable_pin_s, mf_s})
	);

	// start and stop are seen on the synchronised copies only
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			scl_d1_q <= 1'b1;
			sda_d1_q <= 1'b1;
		end
		else
		begin
			scl_d1_q <= bus_width_select_s;
			sda_d1_q <= clock_mode_select_s;
		end
	end

	assign start_seen = serial_port_select_s && bus_width_select_s && scl_d1_q && sda_d1_q && !clock_mode_select_s;
	assign stop_seen  = serial_port_select_s && bus_width_select_s && scl_d1_q && !sda_d1_q && clock_mode_select_s;

	// hold the byte machine in reset from a start or stop until scl falls;
	// scl may not toggle outside a frame, so the core clock owns this
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			frame_hold_q <= 1'b1;
		else if (!serial_port_select_s || start_seen || stop_seen)
			frame_hold_q <= 1'b1;
		else if (!bus_width_select_s && frame_hold_q && !stop_like())
			frame_hold_q <= 1'b0;
	end

	// a released frame needs a start: stop leaves scl high, so only
	// a start that lets scl fall reopens the byte machine
	function automatic logic stop_like();
		stop_like = 1'b0;
	endfunction

	// port select low resets the serial logic at once
	assign frame_rst_n = serial_port_select_in & ~frame_hold_q;

	// address and hot-plug pins into the link domain
	cpm_sync2 #(.W(4)) u_link_sync (
		.clk_in    (bus_width_select_in),
		.arst_n_in (serial_port_select_in),
		.d_in      ({latch_polarity_select_in, multifunction_in}),
		.q_out     (link_pins_s)
	);

	assign byte_now = {shift_q, clock_mode_select_in};

	// readable registers; unmapped indices read as zero
	always_comb
	begin
		case (ptr_q)
			CPM_REG_CTRL_IDX: rd_data = ctrl_q;
			CPM_REG_TRIM_IDX: rd_data = {5'h00, trim_q};
			// hot-plug level visible to the serial master
			CPM_REG_STAT_IDX: rd_data = {7'h00, link_pins_s[3]};
			default:          rd_data = 8'h00;
		endcase
	end

	// bus width pin clocks the slave, clock mode pin is data
	always_ff @(posedge bus_width_select_in or negedge frame_rst_n)
	begin
		if (!frame_rst_n)
		begin
			bit_cnt_q <= 4'h0;
			shift_q   <= 7'h00;
		end
		else if (bit_cnt_q == CPM_BIT_ACK)
			bit_cnt_q <= 4'h0;
		else
		begin
			bit_cnt_q <= bit_cnt_q + 4'h1;
			shift_q   <= byte_now[6:0];
		end
	end

	// byte phase machine; the pointer survives frames until port reset
	always_ff @(posedge bus_width_select_in or negedge frame_rst_n)
	begin
		if (!frame_rst_n)
		begin
			lstate_q  <= LS_ADDR;
			ack_q     <= 1'b0;
			rd_pend_q <= 1'b0;
			tx_q      <= 8'h00;
		end
		else if (bit_cnt_q == CPM_BIT_LAST)
		begin
			ack_q <= 1'b0;
			case (lstate_q)
				// shared pins give the low address bits
				LS_ADDR:
				begin
					if (byte_now[7:1] == {CPM_SLAVE_ADDR_HI, link_pins_s[2:0]})
					begin
						ack_q     <= 1'b1;
						rd_pend_q <= byte_now[0];
					end
					else
						lstate_q <= LS_IDLE;
				end
				LS_REG:   ack_q <= 1'b1;
				LS_WDATA: ack_q <= 1'b1;
				LS_READ:  ack_q <= 1'b0;
				LS_IDLE:  ack_q <= 1'b0;
				default:  lstate_q <= LS_IDLE;
			endcase
		end
		else if (bit_cnt_q == CPM_BIT_ACK)
		begin
			ack_q <= 1'b0;
			case (lstate_q)
				LS_ADDR:
				begin
					if (rd_pend_q)
					begin
						lstate_q  <= LS_READ;
						tx_q      <= rd_data;
						rd_pend_q <= 1'b0;
					end
					// a write moves on to the index byte after its ack
					else
						lstate_q <= LS_REG;
				end
				LS_REG:   lstate_q <= LS_WDATA;
				// master nack ends the read burst
				LS_READ:
				begin
					if (clock_mode_select_in)
						lstate_q <= LS_IDLE;
					else
						tx_q <= rd_data;
				end
				LS_WDATA: lstate_q <= LS_WDATA;
				LS_IDLE:  lstate_q <= LS_IDLE;
				default:  lstate_q <= LS_IDLE;
			endcase
		end
	end

	// registers reset only by port select, not by each start
	// de-skew enable and trim live here in serial mode
	always_ff @(posedge bus_width_select_in or negedge serial_port_select_in)
	begin
		if (!serial_port_select_in)
		begin
			ptr_q    <= 8'h00;
			ctrl_q   <= CPM_CTRL_RST;
			trim_q   <= CPM_TRIM_RST;
			wr_tgl_q <= 1'b0;
		end
		else if (frame_rst_n && bit_cnt_q == CPM_BIT_LAST)
		begin
			if (lstate_q == LS_REG)
				ptr_q <= byte_now;
			else if (lstate_q == LS_WDATA)
			begin
				ptr_q <= ptr_q + 8'h01;
				if (ptr_q == CPM_REG_CTRL_IDX)
				begin
					ctrl_q   <= byte_now;
					wr_tgl_q <= ~wr_tgl_q;
				end
				else if (ptr_q == CPM_REG_TRIM_IDX)
				begin
					trim_q   <= byte_now[2:0];
					wr_tgl_q <= ~wr_tgl_q;
				end
			end
		end
		else if (frame_rst_n && bit_cnt_q == CPM_BIT_ACK &&
		         (lstate_q == LS_READ || (lstate_q == LS_ADDR && rd_pend_q)))
		begin
			// pointer steps past each byte handed to the master
			ptr_q <= ptr_q + 8'h01;
		end
	end

	assign cfg.wr_tgl = wr_tgl_q;
	assign cfg.ctrl   = ctrl_q;
	assign cfg.trim   = trim_q;

	// data changes only while scl is low, hence the falling edge
	always_ff @(negedge bus_width_select_in or negedge frame_rst_n)
	begin
		if (!frame_rst_n)
			sda_oe_n_out <= 1'b1;
		else if (bit_cnt_q == CPM_BIT_ACK)
			sda_oe_n_out <= ~ack_q;
		else if (lstate_q == LS_READ)
			sda_oe_n_out <= tx_q[3'(CPM_BIT_LAST - bit_cnt_q)];
		else
			sda_oe_n_out <= 1'b1;
	end

	// open drain: the pin is only ever pulled low
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			sda_out <= 1'b0;
		else
			sda_out <= 1'b0;
	end

	// settings written over the serial port, in the core domain
	cpm_cfg_regs u_cfg_regs (
		.clk_in       (clk_in),
		.arst_n_in    (arst_n_in),
		.serial_en_in (serial_port_select_s),
		.cfg          (cfg),
		.ctrl_out     (reg_ctrl),
		.trim_out     (reg_trim)
	);

	// serial mode flag follows the port select level
	// strap mode takes every setting from pins
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			serial_enabled_out <= 1'b0;
		else
			serial_enabled_out <= serial_port_select_s;
	end

	// bus width strap, or the control register in serial mode, picks the pixel input mode
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			input_24bit_out <= 1'b0;
		else if (serial_port_select_s)
			input_24bit_out <= reg_ctrl[CPM_CTRL_BUS_WIDTH_SELECT_BIT];
		else
			input_24bit_out <= bus_width_select_s;
	end

	// differential clocking needs low swing in either mode
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			clock_differential_out <= 1'b0;
		else if (serial_port_select_s)
			clock_differential_out <= reg_ctrl[CPM_CTRL_CLOCK_MODE_SELECT_BIT] & swing_s;
		else
			clock_differential_out <= clock_mode_select_s & bus_width_select_s & swing_s;
	end

	// independent of the clock style chosen above
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			latch_rising_out <= 1'b0;
		else if (serial_port_select_s)
			latch_rising_out <= reg_ctrl[CPM_CTRL_EDGE_BIT];
		else
			latch_rising_out <= edge_s;
	end

	// latch pin reports hot-plug only in serial mode
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			hot_plug_sense_out <= 1'b0;
		else
			hot_plug_sense_out <= serial_port_select_s & edge_s;
	end

	// enabled de-skew takes its trim from the shared pins, or from the trim register in serial mode
	// disabled de-skew falls back to the default trim
	// serial mode ignores the de-skew pin entirely
	always_comb
	begin
		if (serial_port_select_s)
			trim_d = reg_ctrl[CPM_CTRL_DESKEW_ENABLE_PIN_BIT] ? reg_trim : CPM_TRIM_RST;
		else
			trim_d = deskew_enable_pin_s ? mf_s : CPM_TRIM_RST;
	end

	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			deskew_enable_out <= 1'b0;
			deskew_trim_out   <= CPM_TRIM_RST;
		end
		else
		begin
			deskew_enable_out <= serial_port_select_s ? reg_ctrl[CPM_CTRL_DESKEW_ENABLE_PIN_BIT] : deskew_enable_pin_s;
			deskew_trim_out   <= trim_d;
		end
	end

	// timing shift is a whole number of trim steps
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			deskew_delay_ps_out <= 12'h000;
		else
			deskew_delay_ps_out <= 12'(32'(trim_d) * TRIM_STEP_PS);
	end

	// blanking controls only with serial and de-skew both off
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			blank_control_out <= 3'h0;
		else if (!serial_port_select_s && !deskew_enable_pin_s)
			blank_control_out <= mf_s;
		else
			blank_control_out <= 3'h0;
	end

	// power strap, or register that defaults to powered down
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			powered_on_out <= 1'b0;
		else if (serial_port_select_s)
			powered_on_out <= reg_ctrl[CPM_CTRL_PD_BIT];
		else
			powered_on_out <= pd_s;
	end

endmodule // cpm_config_pin_mode_select

//--- tb/cpm_sva.sv
// checker on the pin decoder top ports, bound from the bench
// assumes pins hold a few clk cycles before outputs are judged
module cpm_sva
	import cpm_pkg::*;
#(
	parameter int TRIM_STEP_PS = 100
) (
	input wire logic       clk_in,
	input wire logic       arst_n_in,
	input wire logic       serial_port_select_in,
	input wire logic       bus_width_select_in,
	input wire logic       clock_mode_select_in,
	input wire logic       latch_polarity_select_in,
	input wire logic       input_swing_low_in,
	input wire logic       powerdown_n_in,
	input wire logic       deskew_enable_pin_in,
	input wire logic [2:0] multifunction_in,
	input wire logic       input_24bit_out,
	input wire logic       clock_differential_out,
	input wire logic       latch_rising_out,
	input wire logic       deskew_enable_out,
	input wire logic [2:0] deskew_trim_out,
	input wire logic [2:0] blank_control_out,
	input wire logic       powered_on_out,
	input wire logic       hot_plug_sense_out,
	input wire logic       sda_oe_n_out
);
	logic [2:0] calm_q;
	logic [9:0] pins;
	logic [9:0] pins_q;
	logic       moved;
	logic       calm;
	logic       st;
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!arst_n_in);
	// a pin move counts in the cycle it is sampled, not one later
	assign pins = {serial_port_select_in, bus_width_select_in,
		clock_mode_select_in, latch_polarity_select_in,
		input_swing_low_in, powerdown_n_in, deskew_enable_pin_in,
		multifunction_in};
	assign moved = pins != pins_q;
	// cycles since any pin moved; decodes lag pins by three clk
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			calm_q <= 3'h0;
			pins_q <= 10'h000;
		end
		else
		begin
			pins_q <= pins;
			if (moved)
				calm_q <= 3'h0;
			else if (calm_q != 3'h7)
				calm_q <= calm_q + 3'h1;
		end
	end
	assign calm = (calm_q > 3'h3) && !moved;
	// settled strap mode only
	assign st = calm && !serial_port_select_in;
	// strap decodes, judged once pins are settled
	property p_width;
		st |-> input_24bit_out == bus_width_select_in;
	endproperty
	a_width: assert property (p_width) else $error("width");
	property p_diff;
		st |-> clock_differential_out == (clock_mode_select_in &&
			bus_width_select_in && input_swing_low_in);
	endproperty
	a_diff: assert property (p_diff) else $error("clock style");
	property p_latch;
		st |-> latch_rising_out == latch_polarity_select_in;
	endproperty
	a_latch: assert property (p_latch) else $error("edge");
	property p_trim;
		st |-> deskew_enable_out == deskew_enable_pin_in &&
			deskew_trim_out == (deskew_enable_pin_in ?
			multifunction_in : CPM_TRIM_RST);
	endproperty
	a_trim: assert property (p_trim) else $error("trim");
	property p_blank;
		st |-> blank_control_out ==
			(deskew_enable_pin_in ? 3'h0 : multifunction_in);
	endproperty
	a_blank: assert property (p_blank) else $error("blank");
	property p_power;
		st |-> powered_on_out == powerdown_n_in;
	endproperty
	a_power: assert property (p_power) else $error("power");
	// hot-plug only passes through in serial mode
	property p_hpd;
		calm |-> hot_plug_sense_out ==
			(serial_port_select_in && latch_polarity_select_in);
	endproperty
	a_hpd: assert property (p_hpd) else $error("hot plug");
	// port select low frees sda at once
	property p_rel;
		!serial_port_select_in |-> sda_oe_n_out;
	endproperty
	a_rel: assert property (p_rel) else $error("sda held");
	// re-entry to serial mode lands on the reset values
	sequence s_rejoin;
		$rose(serial_port_select_in) ##1 serial_port_select_in [*4];
	endsequence
	property p_dflt;
		s_rejoin |=> !powered_on_out && latch_rising_out &&
			!deskew_enable_out && deskew_trim_out == CPM_TRIM_RST;
	endproperty
	a_dflt: assert property (p_dflt) else $error("defaults");
endmodule // cpm_sva

//--- tb/cpm_i2c_master.sv
// two-wire master model for the serial configuration port
// assumes a pull-up on sda; scl idles high and stands still between frames
module cpm_i2c_master (
	output logic      scl_out,
	output logic      sda_pull_out,
	input  wire logic sda_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle bus: both lines released
	initial
	begin
		scl_out = 1'b1;
		sda_pull_out = 1'b0;
	end
	// start when st, else stop; long holds let the core clock see it
	task automatic cond(input logic st);
		sda_pull_out = !st;
		#12 scl_out = 1'b1;
		#24 sda_pull_out = st;
		#48 scl_out = !st;
		#24;
	endtask
	// nine bits of 48 ns; sda moves only while scl is low
	task automatic xfer(input logic [8:0] d, output logic [8:0] q);
		for (int i = 8; i >= 0; i--)
		begin
			sda_pull_out = !d[i];
			#12 scl_out = 1'b1;
			#12 q[i] = sda_in;
			#12 scl_out = 1'b0;
			#12;
		end
	endtask
endmodule // cpm_i2c_master

//--- tb/cpm_config_pin_mode_select_tb_top.sv
// bench for the pin decoder: strap table, serial mode, select reset
// assumes the master model owns scl and sda while the port is on
module cpm_config_pin_mode_select_tb_top
	import cpm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_in = 1'b0;
	logic        arst_n_in = 1'b0;
	logic        serial_port_select_in = 1'b1;
	logic        bus_width_select = 1'b1;
	logic        clock_mode_select = 1'b1;
	logic        latch_polarity_select_in = 1'b0;
	logic        input_swing_low_in = 1'b0;
	logic        powerdown_n_in = 1'b0;
	logic        deskew_enable_pin_in = 1'b0;
	logic [2:0]  multifunction_in = 3'h0;
	logic        serial_enabled_out, input_24bit_out, latch_rising_out;
	logic        clock_differential_out, deskew_enable_out, sda_out;
	logic        powered_on_out, hot_plug_sense_out, sda_oe_n_out;
	logic [2:0]  deskew_trim_out, blank_control_out;
	logic [11:0] deskew_delay_ps_out;
	logic [8:0]  q;
	wire         scl, pull, bus_width_select_in, clock_mode_select_in;
	int          n_fail = 0;
	int          n_tests = 0;
	// open-drain sda with pull-up; strap levels while the port is off
	assign clock_mode_select_in = serial_port_select_in ?
		(!pull && (sda_oe_n_out || sda_out)) : clock_mode_select;
	assign bus_width_select_in = serial_port_select_in ? scl : bus_width_select;
	always #5 clk_in = ~clk_in;
	cpm_config_pin_mode_select #(.TRIM_STEP_PS(100)) DUT (
		.clk_in                   (clk_in),
		.arst_n_in                (arst_n_in),
		.serial_port_select_in    (serial_port_select_in),
		.bus_width_select_in      (bus_width_select_in),
		.clock_mode_select_in     (clock_mode_select_in),
		.latch_polarity_select_in (latch_polarity_select_in),
		.input_swing_low_in       (input_swing_low_in),
		.powerdown_n_in           (powerdown_n_in),
		.deskew_enable_pin_in     (deskew_enable_pin_in),
		.multifunction_in         (multifunction_in),
		.serial_enabled_out       (serial_enabled_out),
		.input_24bit_out          (input_24bit_out),
		.clock_differential_out   (clock_differential_out),
		.latch_rising_out         (latch_rising_out),
		.deskew_enable_out        (deskew_enable_out),
		.deskew_trim_out          (deskew_trim_out),
		.deskew_delay_ps_out      (deskew_delay_ps_out),
		.blank_control_out        (blank_control_out),
		.powered_on_out           (powered_on_out),
		.hot_plug_sense_out       (hot_plug_sense_out),
		.sda_out                  (sda_out),
		.sda_oe_n_out             (sda_oe_n_out)
	);
	cpm_i2c_master u_mst (.scl_out(scl), .sda_pull_out(pull),
		.sda_in(clock_mode_select_in));
	task automatic chk(input string nm, input logic [11:0] e, g);
		n_tests++;
		if (g !== e)
		begin
			n_fail++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic final_report();
		if (n_fail == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// one strap vector, checked after the three-clk sync lag
	task automatic strap(input logic [4:0] i);
		logic [2:0] t;
		@(posedge clk_in);
		{bus_width_select, clock_mode_select, latch_polarity_select_in, input_swing_low_in} <= i[3:0];
		deskew_enable_pin_in <= i[4];
		powerdown_n_in <= i[1] ^ i[2];
		multifunction_in <= i[2:0] ^ i[4:2];
		repeat (5) @(posedge clk_in);
		t = i[4] ? multifunction_in : CPM_TRIM_RST;
		chk("mode", 0, serial_enabled_out);
		chk("width", bus_width_select, input_24bit_out);
		chk("diff", bus_width_select & clock_mode_select & i[0], clock_differential_out);
		chk("latch", i[1], latch_rising_out);
		chk("deskew_enable_pin", i[4], deskew_enable_out);
		chk("trim", t, deskew_trim_out);
		chk("delay", t * 100, deskew_delay_ps_out);
		chk("blank", i[4] ? 0 : multifunction_in, blank_control_out);
		chk("power", powerdown_n_in, powered_on_out);
		chk("hpd", 0, hot_plug_sense_out);
	endtask
	// serial-mode reset values; the de-skew pin is tied high meanwhile
	task automatic dflt();
		chk("mode", 1, serial_enabled_out);
		chk("power", 0, powered_on_out);
		chk("latch", 1, latch_rising_out);
		chk("deskew_enable_pin", 0, deskew_enable_out);
		chk("trim", CPM_TRIM_RST, deskew_trim_out);
		chk("hpd", 1, hot_plug_sense_out);
	endtask
	// write frame; the master sends every byte even when refused
	task automatic wr(input logic [7:0] ad, ix, dt, input logic ack);
		u_mst.cond(1'b1);
		u_mst.xfer({ad, 1'b1}, q);
		chk("addr ack", ack, !q[0]);
		u_mst.xfer({ix, 1'b1}, q);
		u_mst.xfer({dt, 1'b1}, q);
		u_mst.cond(1'b0);
	endtask
	initial
	begin
		// a real falling select at start clears the link-domain registers
		serial_port_select_in <= 1'b0;
		repeat (6) @(posedge clk_in);
		arst_n_in <= 1'b1;
		for (int i = 0; i < 32; i++)
			strap(i[4:0]);
		// settle pins for serial entry: scl and sda idle high
		{bus_width_select, clock_mode_select, latch_polarity_select_in} <= 3'h7;
		{input_swing_low_in, deskew_enable_pin_in} <= 2'h3;
		{multifunction_in, powerdown_n_in} <= 4'h5;
		@(posedge clk_in);
		serial_port_select_in <= 1'b1;
		repeat (6) @(posedge clk_in);
		wr(8'h7a, 8'h08, 8'h1f, 1'b0);
		repeat (8) @(posedge clk_in);
		dflt();
		wr(8'h74, 8'h0a, 8'h03, 1'b1);
		wr(8'h74, 8'h08, 8'h1f, 1'b1);
		repeat (8) @(posedge clk_in);
		chk("power", 1, powered_on_out);
		chk("deskew_enable_pin", 1, deskew_enable_out);
		chk("trim", 3, deskew_trim_out);
		chk("delay", 300, deskew_delay_ps_out);
		// pointer set, then read two bytes through a repeated start
		u_mst.cond(1'b1);
		u_mst.xfer(9'h0e9, q);
		u_mst.xfer(9'h011, q);
		u_mst.cond(1'b1);
		u_mst.xfer(9'h0eb, q);
		chk("rd ack", 0, q[0]);
		u_mst.xfer(9'h1fe, q);
		chk("ctrl", 8'h1f, q[8:1]);
		u_mst.xfer(9'h1ff, q);
		chk("stat", 8'h01, q[8:1]);
		u_mst.cond(1'b0);
		// short low on port select wipes the registers
		@(posedge clk_in);
		serial_port_select_in <= 1'b0;
		repeat (5) @(posedge clk_in);
		chk("mode", 0, serial_enabled_out);
		serial_port_select_in <= 1'b1;
		repeat (6) @(posedge clk_in);
		dflt();
		final_report();
	end
	// hang guard, far past the nine or so microseconds the run needs
	initial
	begin
		#100000;
		n_fail++;
		final_report();
	end
endmodule // cpm_config_pin_mode_select_tb_top
bind cpm_config_pin_mode_select cpm_sva #(.TRIM_STEP_PS(TRIM_STEP_PS))
	u_sva (
		.clk_in                   (clk_in),
		.arst_n_in                (arst_n_in),
		.serial_port_select_in    (serial_port_select_in),
		.bus_width_select_in      (bus_width_select_in),
		.clock_mode_select_in     (clock_mode_select_in),
		.latch_polarity_select_in (latch_polarity_select_in),
		.input_swing_low_in       (input_swing_low_in),
		.powerdown_n_in           (powerdown_n_in),
		.deskew_enable_pin_in     (deskew_enable_pin_in),
		.multifunction_in         (multifunction_in),
		.input_24bit_out          (input_24bit_out),
		.clock_differential_out   (clock_differential_out),
		.latch_rising_out         (latch_rising_out),
		.deskew_enable_out        (deskew_enable_out),
		.deskew_trim_out          (deskew_trim_out),
		.blank_control_out        (blank_control_out),
		.powered_on_out           (powered_on_out),
		.hot_plug_sense_out       (hot_plug_sense_out),
		.sda_oe_n_out             (sda_oe_n_out)
	);
